// [src/pacc_params.svh]
// Offsets, field positions, masks and timing constants of the pulse accumulator
`ifndef PACC_PARAMS_SVH
`define PACC_PARAMS_SVH
// Register indices; byte address is four times the index
`define PACC_IDX_COUNT1    6'h00
`define PACC_IDX_COUNT2    6'h01
`define PACC_IDX_CMP1      6'h02
`define PACC_IDX_CMP2      6'h03
`define PACC_IDX_SNAP1     6'h04
`define PACC_IDX_SNAP2     6'h05
`define PACC_IDX_LOCK_LIM  6'h0c
`define PACC_IDX_CH1       6'h0d
`define PACC_IDX_CH2       6'h0e
// Configuration and status bit positions
`define PACC_B_MODCFG      0
`define PACC_B_FORCE       1
`define PACC_B_EN          2
`define PACC_B_RST_SNAP    3
`define PACC_B_CMP_SNAP    4
`define PACC_B_DEB_CNT     5
`define PACC_B_FUSE        6
`define PACC_B_RST_RD      7
`define PACC_B_CNT_TRAIL   8
`define PACC_B_SNAP_TRAIL  9
`define PACC_B_GATE_OFF    10
`define PACC_B_NO_DEB      11
`define PACC_B_GATE_LIVE   12
`define PACC_B_SEL_LO      14
// Writable bits of each channel word
`define PACC_WMASK_CH1     16'hcfbf
`define PACC_WMASK_CH2     16'hcfbc
`define PACC_CFG_RESET     16'h0000
// Timing
`define PACC_CLK_HZ        250000000
`define PACC_TB_FAST_HZ    100000
`define PACC_DECADE        4'h9
`define PACC_DEB_CYCLES    16
`endif

// [src/pacc_pkg.sv]
// Types shared by the pulse accumulator control logic
package pacc_pkg;
   typedef enum logic [1:0] {PACC_SRC_EXT, PACC_SRC_1K, PACC_SRC_10K, PACC_SRC_100K} pacc_src_t;

   typedef struct packed {
      logic [1:0] count;
      logic [1:0] gate;
      logic [1:0] capture;
   } pacc_pins_t;

   typedef struct packed {
      logic [1:0][15:0]       cfg;      // Stored configuration words
      logic [1:0][31:0]       count;
      logic [1:0][31:0]       cmp;
      logic [1:0][31:0]       snap;
      logic [1:0][2:0][2:0]   sync;     // Per channel: count, gate, capture
      logic [1:0][2:0]        agreed;
      logic [1:0][2:0]        filt;
      logic [1:0][2:0][15:0]  deb;
      logic [1:0][2:0]        last;     // Previous used level
      logic [2:0]             fuse_sync;
      logic                   fuse;
      logic [31:0]            tb_cnt;
      logic [3:0]             dec10;
      logic [3:0]             dec1;
      logic [2:0]             tick;     // 1k, 10k, 100k enables
      logic [31:0]            prdata;
      logic                   pslverr;
   } pacc_state_t;
endpackage

// [src/pacc_ctrl.sv]
// Two-channel pulse accumulator configuration, status and counting logic
`include "pacc_params.svh"

module pacc_ctrl
   import pacc_pkg::*;
#(
   parameter int DEB_CYCLES = `PACC_DEB_CYCLES,
   parameter int TB_DIV     = `PACC_CLK_HZ / `PACC_TB_FAST_HZ
) (
   input  wire logic        pclk,           // Bus clock
   input  wire logic        presetn,        // Async reset, active low
   input  wire logic        psel,           // APB select
   input  wire logic        penable,        // APB access phase
   input  wire logic        pwrite,         // APB direction
   input  wire logic [7:0]  paddr,          // APB byte address
   input  wire logic [31:0] pwdata,         // APB write data
   output logic      [31:0] prdata,         // APB read data
   output logic             pready,         // APB ready, never waits
   output logic             pslverr,        // Attention or unmapped
   input  wire pacc_pins_t  pins,           // Field inputs, asynchronous
   input  wire logic        fuse_blown_pin, // Field fuse blown, async
   output logic             module_error,   // Forced or external error
   output logic [1:0]       gate_active     // Live gate level per channel
);

   pacc_state_t r;
   pacc_state_t next_r;

   // Field side of a channel signal: bypass or debounced level
   function automatic logic pick_level(input logic bypass, input logic raw, input logic fil);
      pick_level = bypass ? raw : fil;
   endfunction

   // Edge of a level: trailing (falling) or leading (rising)
   function automatic logic edge_of(input logic trail, input logic prev, input logic now);
      edge_of = trail ? (prev & ~now) : (~prev & now);
   endfunction

   logic [5:0] idx;
   logic       setup;
   logic       access;
   logic       low_reg;
   logic       locked;
   logic       fault;
   logic       mapped;

   // Address decode shared by setup and access phases
   always_comb begin
      idx     = paddr[7:2];
      setup   = psel & ~penable;
      access  = psel & penable;
      low_reg = idx < `PACC_IDX_LOCK_LIM;
      locked  = low_reg & ~r.cfg[0][`PACC_B_MODCFG];
      fault   = low_reg & r.cfg[0][`PACC_B_FORCE];
      mapped  = (idx <= `PACC_IDX_SNAP2) | (idx == `PACC_IDX_CH1) | (idx == `PACC_IDX_CH2);
   end

   // Status word of one channel
   function automatic logic [15:0] status_of(input pacc_state_t s, input int c);
      logic [15:0] w;
      w = s.cfg[c];
      w[`PACC_B_FUSE] = s.fuse;
      w[`PACC_B_GATE_LIVE] = pick_level(s.cfg[c][`PACC_B_NO_DEB], s.agreed[c][1], s.filt[c][1]);
      w[13] = 1'b0;
      if (c == 1) begin
         w[1:0] = 2'b00;
      end
      status_of = w;
   endfunction

   logic [1:0] lvl_cnt;
   logic [1:0] lvl_gate;
   logic [1:0] lvl_cap;
   logic [1:0] run;
   logic [1:0] inc;
   logic [1:0] cap;
   logic [1:0] rd_clr;
   logic [31:0] rd_word;

   // Whole next state in one pass
   always_comb begin
      next_r = r;
      lvl_cnt = '0;
      lvl_gate = '0;
      lvl_cap = '0;
      run = '0;
      inc = '0;
      cap = '0;
      rd_clr = '0;
      rd_word = '0;

      // Timebase dividers, single-cycle enables
      next_r.tick = 3'b000;
      if (r.tb_cnt >= 32'(TB_DIV - 1)) begin
         next_r.tb_cnt = '0;
         next_r.tick[2] = 1'b1;
         if (r.dec10 == `PACC_DECADE) begin
            next_r.dec10 = '0;
            next_r.tick[1] = 1'b1;
            if (r.dec1 == `PACC_DECADE) begin
               next_r.dec1 = '0;
               next_r.tick[0] = 1'b1;
            end else begin
               next_r.dec1 = r.dec1 + 4'h1;
            end
         end else begin
            next_r.dec10 = r.dec10 + 4'h1;
         end
      end else begin
         next_r.tb_cnt = r.tb_cnt + 32'h1;
      end

      // Fuse input: three flops, change taken when last two agree
      next_r.fuse_sync = {r.fuse_sync[1:0], fuse_blown_pin};
      if (r.fuse_sync[1] == r.fuse_sync[2]) begin
         next_r.fuse = r.fuse_sync[2];
      end

      for (int c = 0; c < 2; c++) begin
         // Synchronise count, gate and capture pins
         next_r.sync[c][0] = {r.sync[c][0][1:0], pins.count[c]};
         next_r.sync[c][1] = {r.sync[c][1][1:0], pins.gate[c]};
         next_r.sync[c][2] = {r.sync[c][2][1:0], pins.capture[c]};
         for (int k = 0; k < 3; k++) begin
            if (r.sync[c][k][1] == r.sync[c][k][2]) begin
               next_r.agreed[c][k] = r.sync[c][k][2];
            end
            // Debounce: accept only after DEB_CYCLES stable cycles
            if (r.agreed[c][k] != r.filt[c][k]) begin
               if (r.deb[c][k] >= 16'(DEB_CYCLES - 1)) begin
                  next_r.filt[c][k] = r.agreed[c][k];
                  next_r.deb[c][k] = '0;
               end else begin
                  next_r.deb[c][k] = r.deb[c][k] + 16'h1;
               end
            end else begin
               next_r.deb[c][k] = '0;
            end
         end

         // Levels after optional filtering
         lvl_cnt[c]  = pick_level(~r.cfg[c][`PACC_B_DEB_CNT], r.agreed[c][0], r.filt[c][0]);
         lvl_gate[c] = pick_level(r.cfg[c][`PACC_B_NO_DEB], r.agreed[c][1], r.filt[c][1]);
         lvl_cap[c]  = pick_level(r.cfg[c][`PACC_B_NO_DEB], r.agreed[c][2], r.filt[c][2]);
         next_r.last[c] = {lvl_cap[c], lvl_gate[c], lvl_cnt[c]};

         // Counter runs when module configured, enabled and gate allows
         run[c] = r.cfg[0][`PACC_B_MODCFG] & r.cfg[c][`PACC_B_EN]
                  & (lvl_gate[c] ^ r.cfg[c][`PACC_B_GATE_OFF]);

         // Count source selection
         case (pacc_src_t'(r.cfg[c][15:14]))
            PACC_SRC_EXT:  inc[c] = edge_of(r.cfg[c][`PACC_B_CNT_TRAIL], r.last[c][0], lvl_cnt[c]);
            PACC_SRC_1K:   inc[c] = r.tick[0];
            PACC_SRC_10K:  inc[c] = r.tick[1];
            PACC_SRC_100K: inc[c] = r.tick[2];
            default:       inc[c] = 1'b0;
         endcase
         inc[c] = inc[c] & run[c];
         if (inc[c]) begin
            next_r.count[c] = r.count[c] + 32'h1;
         end

         // Capture on external edge or on compare match
         cap[c] = edge_of(r.cfg[c][`PACC_B_SNAP_TRAIL], r.last[c][2], lvl_cap[c]);
         if (r.cfg[c][`PACC_B_CMP_SNAP] && inc[c] && (next_r.count[c] == r.cmp[c])) begin
            cap[c] = 1'b1;
         end
         if (cap[c] && r.cfg[0][`PACC_B_MODCFG]) begin
            next_r.snap[c] = next_r.count[c];
            if (r.cfg[c][`PACC_B_RST_SNAP]) begin
               next_r.count[c] = '0;
            end
         end
      end

      // Setup phase: latch answer so data is ready in access phase
      if (setup) begin
         case (idx)
            `PACC_IDX_COUNT1: rd_word = r.count[0];
            `PACC_IDX_COUNT2: rd_word = r.count[1];
            `PACC_IDX_CMP1:   rd_word = r.cmp[0];
            `PACC_IDX_CMP2:   rd_word = r.cmp[1];
            `PACC_IDX_SNAP1:  rd_word = r.snap[0];
            `PACC_IDX_SNAP2:  rd_word = r.snap[1];
            `PACC_IDX_CH1:    rd_word = {16'h0000, status_of(r, 0)};
            `PACC_IDX_CH2:    rd_word = {16'h0000, status_of(r, 1)};
            default:          rd_word = 32'h0000_0000;
         endcase
         // Locked or faulted low registers give no data
         next_r.prdata  = (locked | fault | pwrite) ? 32'h0000_0000 : rd_word;
         next_r.pslverr = fault | ~mapped;
      end

      // Access phase: writes and read side effects
      if (access && !locked && !fault) begin
         if (pwrite) begin
            case (idx)
               `PACC_IDX_CMP1: next_r.cmp[0] = pwdata;
               `PACC_IDX_CMP2: next_r.cmp[1] = pwdata;
               `PACC_IDX_CH1:  next_r.cfg[0] = pwdata[15:0] & `PACC_WMASK_CH1;
               `PACC_IDX_CH2:  next_r.cfg[1] = pwdata[15:0] & `PACC_WMASK_CH2;
               default: ;
            endcase
         end else begin
            rd_clr[0] = (idx == `PACC_IDX_COUNT1) & r.cfg[0][`PACC_B_RST_RD];
            rd_clr[1] = (idx == `PACC_IDX_COUNT2) & r.cfg[1][`PACC_B_RST_RD];
         end
      end
      for (int c = 0; c < 2; c++) begin
         // Clear after read; a pulse in the same cycle is lost to the clear
         if (rd_clr[c]) begin
            next_r.count[c] = '0;
         end
      end

      // Unconfigured module holds both counters in reset
      if (!r.cfg[0][`PACC_B_MODCFG]) begin
         next_r.count = '0;
      end
   end

   // State register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   // Outputs
   assign prdata       = r.prdata;
   assign pslverr      = r.pslverr;
   assign pready       = 1'b1;                                                // Zero wait states
   assign module_error = r.cfg[0][`PACC_B_FORCE] | r.fuse;
   assign gate_active  = {pick_level(r.cfg[1][`PACC_B_NO_DEB], r.agreed[1][1], r.filt[1][1]),
                          pick_level(r.cfg[0][`PACC_B_NO_DEB], r.agreed[0][1], r.filt[0][1])};

endmodule // pacc_ctrl

// [verification/pacc_ctrl_props.sv]
// Port checker for the pulse accumulator control block
module pacc_ctrl_props
   import pacc_pkg::*;
(
   input wire logic        pclk,           // Clock
   input wire logic        presetn,        // Reset, active low
   input wire logic        psel,           // Select
   input wire logic        penable,        // Access phase
   input wire logic        pwrite,         // Direction
   input wire logic [7:0]  paddr,          // Byte address
   input wire logic [31:0] pwdata,         // Write data
   input wire logic [31:0] prdata,         // Read data
   input wire logic        pready,         // Ready
   input wire logic        pslverr,        // Attention
   input wire pacc_pins_t  pins,           // Field levels
   input wire logic        fuse_blown_pin, // Fuse blown
   input wire logic        module_error,   // Error flag
   input wire logic [1:0]  gate_active     // Live gate
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] w1; // Expected stored channel words
   logic [15:0] w2;
   logic [5:0]  idx;
   logic        rd;
   assign idx = paddr[7:2];
   assign rd = psel && !penable && !pwrite;
   // Mirror words at the access edge, so status reads can be judged
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         w1 <= 16'h0000;
         w2 <= 16'h0000;
      end else if (psel && penable && pwrite && pready) begin
         if (idx == 6'h0d) w1 <= pwdata[15:0] & 16'hcfbf;
         if (idx == 6'h0e) w2 <= pwdata[15:0] & 16'hcfbc;
      end
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   ch1_readback_a: assert property (rd && idx == 6'h0d |=> (prdata & 32'hcfbf) == {16'h0000, w1})
      else $error("channel one status mismatch");
   ch2_readback_a: assert property (rd && idx == 6'h0e |=> (prdata & 32'hcfbf) == {16'h0000, w2})
      else $error("channel two status mismatch");
   locked_read_a: assert property (rd && idx < 6'h0c && !w1[0] && !w1[1] |=> prdata == 32'h0 && !pslverr)
      else $error("locked register answered");
   forced_attn_a: assert property (psel && !penable && idx < 6'h0c && w1[1:0] == 2'b11 |=> pslverr)
      else $error("no attention on forced error");
   force_err_a: assert property (w1[1] [*2] |-> module_error)
      else $error("forced error flag low");
   fuse_err_a: assert property (fuse_blown_pin [*6] |-> module_error)
      else $error("fuse error flag low");
   gate_status_a: assert property (rd && idx == 6'h0d |=> prdata[12] == $past(gate_active[0]))
      else $error("gate status mismatch");
   fuse_status_a: assert property (rd && idx == 6'h0d && !w1[1] && !$past(w1[1]) |=> prdata[6] == $past(module_error))
      else $error("fuse status mismatch");
   unmapped_a: assert property (psel && !penable && idx > 6'h0e |=> pslverr)
      else $error("unmapped index accepted");
endmodule // pacc_ctrl_props

bind pacc_ctrl pacc_ctrl_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .pins(pins), .fuse_blown_pin(fuse_blown_pin), .module_error(module_error), .gate_active(gate_active));

// [verification/pacc_field.sv]
// Field side model: count pulses, gate level and fuse state
module pacc_field
   import pacc_pkg::*;
(
   input  wire logic pclk, // Bench clock
   output pacc_pins_t pins, // Field levels
   output logic       fuse  // Fuse blown
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      pins = '0;
      fuse = 1'b0;
   end
   // Pulses long enough to pass sync and debounce stages
   task automatic pulse(input int ch, input int n);
      repeat (n) begin
         @(posedge pclk);
         pins.count[ch] <= 1'b1;
         repeat (8) @(posedge pclk);
         pins.count[ch] <= 1'b0;
         repeat (8) @(posedge pclk);
      end
   endtask
   // Capture pulse, long enough to pass sync and debounce stages
   task automatic snap(input int ch);
      @(posedge pclk);
      pins.capture[ch] <= 1'b1;
      repeat (8) @(posedge pclk);
      pins.capture[ch] <= 1'b0;
      repeat (8) @(posedge pclk);
   endtask
   // Gate and fuse levels, then settle time
   task automatic set_lvl(input logic g, input logic f);
      @(posedge pclk);
      pins.gate[0] <= g;
      fuse <= f;
      repeat (20) @(posedge pclk);
   endtask
endmodule // pacc_field

// [verification/tb_top.sv]
// Self-checking bench for the pulse accumulator control block
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct {logic [7:0] a; logic [31:0] w; logic [31:0] e;} pacc_row_t;
   logic               pclk, presetn, psel, penable, pwrite, pready, pslverr, fuse, module_error, rerr;
   logic [7:0]         paddr;
   logic [31:0]        pwdata, prdata, rdat;
   logic [1:0]         gate_active;
   pacc_pkg::pacc_pins_t pins;
   int                 error_cnt = 0;
   int                 checked = 0;
   pacc_row_t rows[9] = '{'{8'h34, 32'h1, 32'h1}, '{8'h38, 32'hffff, 32'hcfbc}, '{8'h38, 32'h4000, 32'h4000},
      '{8'h38, 32'h8000, 32'h8000}, '{8'h38, 32'hc000, 32'hc000}, '{8'h38, 32'h0, 32'h0},
      '{8'h08, 32'h12345678, 32'h12345678}, '{8'h00, 32'hffffffff, 32'h0}, '{8'h14, 32'h1, 32'h0}};

   // Short dividers keep the timebase and debounce runs brief
   pacc_ctrl #(.DEB_CYCLES(4), .TB_DIV(5)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .pins(pins), .fuse_blown_pin(fuse), .module_error(module_error), .gate_active(gate_active));
   pacc_field u_fld (.pclk(pclk), .pins(pins), .fuse(fuse));

   task automatic print_verdict();
      if (error_cnt == 0 && checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic chkw(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] %0t word %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chkb(input logic got, input logic exp);
      checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] %0t flag %b expected %b", $time, got, exp);
      end
   endtask
   // One transfer; request held until ready is seen, bounded wait
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
      if (n >= 20) begin
         error_cnt++;
         $display("[ERR] %0t no ready", $time);
         print_verdict();
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a);
      xfer(1'b0, a, 32'h0);
   endtask

   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      // Low registers locked until configured
      wr(8'h08, 32'h5);
      rd(8'h08);
      chkb(rerr, 1'b0);
      wr(8'h34, 32'h1);
      rd(8'h08);
      chkw(rdat, 32'h0);
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].w);
         rd(rows[i].a);
         chkw(rdat, rows[i].e);
      end
      // Forced error, then an unmapped index
      wr(8'h34, 32'h3);
      rd(8'h08);
      chkb(rerr, 1'b1);
      chkb(module_error, 1'b1);
      rd(8'h34);
      chkw(rdat, 32'h3);
      rd(8'h3c);
      chkb(rerr, 1'b1);
      // Leading-edge counting with gate asserted
      wr(8'h34, 32'h1);
      u_fld.set_lvl(1'b1, 1'b0);
      chkb(gate_active[0], 1'b1);
      chkb(gate_active[1], 1'b0);
      wr(8'h34, 32'h5);
      u_fld.pulse(0, 3);
      rd(8'h00);
      chkw(rdat, 32'h3);
      wr(8'h34, 32'h85);
      rd(8'h00);
      rd(8'h00);
      chkw(rdat, 32'h0);
      // Compare capture with clear on capture
      wr(8'h08, 32'h2);
      wr(8'h34, 32'h1d);
      u_fld.pulse(0, 3);
      rd(8'h10);
      chkw(rdat, 32'h2);
      rd(8'h00);
      chkw(rdat, 32'h1);
      // Inverted gate sense stops counting
      wr(8'h34, 32'h405);
      u_fld.pulse(0, 2);
      rd(8'h00);
      chkw(rdat, 32'h1);
      rd(8'h34);
      chkw(rdat, 32'h1405);
      // Fast timebase: about one tick per five cycles
      wr(8'h34, 32'hc005);
      repeat (100) @(posedge pclk);
      rd(8'h00);
      chkb(rdat >= 32'd16 && rdat <= 32'd30, 1'b1);
      wr(8'h34, 32'h0);
      wr(8'h34, 32'h1);
      rd(8'h00);
      chkw(rdat, 32'h0);
      // Trailing-edge counting, then an external capture with filters bypassed
      wr(8'h34, 32'h105);
      u_fld.pulse(0, 3);
      rd(8'h00);
      chkw(rdat, 32'h3);
      wr(8'h34, 32'ha05);
      u_fld.snap(0);
      rd(8'h10);
      chkw(rdat, 32'h3);
      wr(8'h34, 32'h1);
      u_fld.set_lvl(1'b1, 1'b1);
      chkb(module_error, 1'b1);
      rd(8'h34);
      chkw(rdat, 32'h1041);
      print_verdict();
   end
endmodule // tb_top
